//--- sfm_cfg.svh
`ifndef SFM_CFG_SVH
`define SFM_CFG_SVH

// ----------------------------------------
// Opcodes served by the front end
// ----------------------------------------
`define SFM_OP_WRSR 8'h01
`define SFM_OP_WRITE 8'h02
`define SFM_OP_READ 8'h03
`define SFM_OP_RDSR 8'h05
`define SFM_OP_DUAL_READ 8'h3B
`define SFM_OP_QUAD_READ 8'h6B
`define SFM_OP_QUAD_IO_READ 8'hEB

// ----------------------------------------
// Array, address and status layout
// ----------------------------------------
`define SFM_MEM_BYTES 524288
`define SFM_ADDR_BITS 24
`define SFM_ADDR_USED 19
`define SFM_ADDR_BYTES 3
`define SFM_SWD_BIT 7
`define SFM_SR_RST 8'h00

// ----------------------------------------
// Timing and buffering
// ----------------------------------------
`define SFM_SCK_MAX_MHZ 108
`define SFM_CLOCK_MHZ 25
`define SFM_SYNC_STAGES 3
`define SFM_FIFO_DEPTH 16

`endif

//--- sfm_master.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Serial bus master model
// ----------------------------------------
module sfm_master (
    output logic sck,
    output logic csN,
    output logic [3:0] laneIn,
    input wire logic [3:0] laneOut,
    input wire logic [3:0] laneOe
);
    logic [3:0] mOut;
    logic [3:0] mOe;
    logic [3:0] lastOe;
    logic wpN;
    logic rstN;
    logic mode3;
    logic q;

    // Idle levels: deselected, clock still
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        mOut = 4'h0;
        mOe = 4'h0;
        lastOe = 4'h0;
        wpN = 1'b1;
        rstN = 1'b1;
        mode3 = 1'b0;
        q = 1'b0;
    end

    // Wire level: device first, then master, else pull-up or a flipped stale level
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            if (laneOe[k]) laneIn[k] = laneOut[k];
            else if (k >= 2 && !q) laneIn[k] = (k == 2) ? wpN : rstN;
            else if (mOe[k]) laneIn[k] = mOut[k];
            else laneIn[k] = (k >= 2) ? 1'b1 : ~mOut[k];
        end
    end

    // Select falls before every opcode; clock idles at the mode level
    task automatic start();
        #7; // Odd lead-in lets the link clock drift against the system clock
        sck = mode3;
        #40 csN = 1'b0;
        #40;
        if (mode3) begin
            sck = 1'b0;
            #40;
        end
    endtask

    // Clock stops low until select is high again
    task automatic stop();
        #40 csN = 1'b1;
        mOe = 4'h0;
        q = 1'b0;
        #40 sck = mode3;
        #160;
    endtask

    // One byte over w lanes, driven when drv, sampled at each rising edge
    task automatic xfer(input logic [7:0] b, input int w, input bit drv, output logic [7:0] r);
        logic [7:0] sh;
        logic [3:0] smp;
        sh = b;
        r = 8'h00;
        q = (w == 4);
        for (int g = 0; g < 8 / w; g++) begin
            for (int k = 0; k < w; k++) mOut[w - 1 - k] = sh[7 - k];
            mOe = drv ? ((w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hF) : 4'h0;
            sh = 8'(sh << w);
            #40 sck = 1'b1;
            smp = (w == 1) ? {3'b000, laneIn[1]} : laneIn;
            lastOe = laneOe;
            for (int k = 0; k < w; k++) r = {r[6:0], smp[w - 1 - k]};
            #40 sck = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

//--- sfm_pkg.sv
`include "sfm_cfg.svh"

package sfm_pkg;

    // ----------------------------------------
    // Link phases and lane widths
    // ----------------------------------------
    typedef enum logic [2:0] {
        PH_OPC = 3'b000,
        PH_ADDR = 3'b001,
        PH_WDATA = 3'b010,
        PH_RDATA = 3'b011,
        PH_STAT = 3'b100,
        PH_IGNORE = 3'b101
    } sfm_phase_e;

    typedef enum logic [1:0] {
        LN_ONE = 2'b00,
        LN_TWO = 2'b01,
        LN_FOUR = 2'b10
    } sfm_lanes_e;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [`SFM_ADDR_USED-1:0] addr;
        logic [7:0] data;
    } sfm_wr_s;

    // Shift state, cleared whenever the chip is deselected
    typedef struct packed {
        sfm_phase_e phase;
        sfm_lanes_e rxLanes;
        sfm_lanes_e txLanes;
        logic [2:0] cnt;
        logic [1:0] addrBytes;
        logic [7:0] shift;
        logic [`SFM_ADDR_BITS-1:0] addr;
        logic isWrite;
        logic srcStatus;
        logic quad;
    } sfm_link_s;

    // State that survives deselect
    typedef struct packed {
        logic [7:0] statusReg;
        sfm_wr_s wrWord;
        logic wrTgl;
    } sfm_keep_s;

    // Lane drivers, launched on the falling edge
    typedef struct packed {
        logic [3:0] laneOut;
        logic [3:0] laneOe;
    } sfm_drive_s;

    // System clock side
    typedef struct packed {
        logic [`SFM_SYNC_STAGES-1:0] tglSync;
        logic tglStable;
        logic tglSeen;
        logic [`SFM_SYNC_STAGES-1:0] csSync;
        logic selected;
    } sfm_sys_s;

endpackage

//--- sfm_spi_front_end.sv
// Operation
// - Active only while chip select low
// - Serial clock used only while selected
// - Sample on rising, launch on falling
// - Fully static, clock may pause anywhere
// - Single lane output driven only on reads
// - Dual/quad: lanes zero, one bidirectional
// - Quad: protect and reset pins become lanes
// - Protect pin plus disable bit block status writes
// - Reset pin low resets, then reinitialises
// - Byte memory of 524288 locations
// - Opcode then three address bytes
// - Only low 19 address bits decoded
// - Accesses finish within the transfer; writes here wait in the buffer until the array port takes them
// - Modes 0 and 3, first rising edge
// - First byte after select is opcode
// - Deselect or reset returns to one lane
`timescale 1ns/1ns
`default_nettype none
`include "sfm_cfg.svh"

// ----------------------------------------
// Write buffer
// ----------------------------------------
module sfm_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = `SFM_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [CW-1:0] count_r;
    logic push;
    logic pop;

    // Honest flags from the fill count
    assign inReady = (count_r != CW'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Pointers wrap at the depth
    always_ff @(posedge clock) begin
        if (srst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                mem[wrPtr_r] <= inData;
                wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------
// Serial front end
// ----------------------------------------
module sfm_spi_front_end #(
    parameter int MEM_BYTES = `SFM_MEM_BYTES,
    parameter int FIFO_DEPTH = `SFM_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic sck,
    input wire logic csN,
    input wire logic [3:0] laneIn,
    output logic [3:0] laneOut,
    output logic [3:0] laneOe,
    output logic [`SFM_ADDR_USED-1:0] memRdAddr,
    input wire logic [7:0] memRdData,
    output logic memWrValid,
    input wire logic memWrReady,
    output logic [`SFM_ADDR_USED-1:0] memWrAddr,
    output logic [7:0] memWrData,
    output logic hostSelected
);
    sfm_pkg::sfm_link_s lnk_r;
    sfm_pkg::sfm_link_s lnk_nxt;
    sfm_pkg::sfm_keep_s keep_r;
    sfm_pkg::sfm_keep_s keep_nxt;
    sfm_pkg::sfm_drive_s drv_r;
    sfm_pkg::sfm_drive_s drv_nxt;
    sfm_pkg::sfm_sys_s sys_r;
    sfm_pkg::sfm_sys_s sys_nxt;
    sfm_pkg::sfm_wr_s fifoOut;
    logic hwRst;
    logic linkRst;
    logic byteDone;
    logic [7:0] rxByte;
    logic [7:0] txByte;
    logic [7:0] txShift;
    logic push;
    logic fifoReady;

    // Last group index of a byte for a lane width
    function automatic logic [2:0] lastCnt(input sfm_pkg::sfm_lanes_e w);
        case (w)
            sfm_pkg::LN_TWO: lastCnt = 3'h3;
            sfm_pkg::LN_FOUR: lastCnt = 3'h1;
            default: lastCnt = 3'h7;
        endcase
    endfunction

    // Shift a group in, most significant first
    function automatic logic [7:0] shiftIn(input logic [7:0] sh, input sfm_pkg::sfm_lanes_e w,
                                           input logic [3:0] ln);
        case (w)
            sfm_pkg::LN_TWO: shiftIn = {sh[5:0], ln[1], ln[0]};
            sfm_pkg::LN_FOUR: shiftIn = {sh[3:0], ln[3], ln[2], ln[1], ln[0]};
            default: shiftIn = {sh[6:0], ln[0]};
        endcase
    endfunction

    // ----------------------------------------
    // Link resets
    // ----------------------------------------
    // Reset pin counts only while lane three is not in use
    assign hwRst = !laneIn[3] && !lnk_r.quad;
    // Deselect holds the shift logic and the lane drivers in reset
    assign linkRst = csN || hwRst;

    assign byteDone = (lnk_r.cnt == lastCnt(lnk_r.rxLanes));
    assign rxByte = shiftIn(lnk_r.shift, lnk_r.rxLanes, laneIn);

    // ----------------------------------------
    // Rising edge: command, address and data
    // ----------------------------------------
    always_comb begin
        lnk_nxt = lnk_r;
        keep_nxt = keep_r;
        case (lnk_r.phase)
            sfm_pkg::PH_OPC: begin
                lnk_nxt.shift = rxByte;
                lnk_nxt.cnt = lnk_r.cnt + 3'h1;
                if (byteDone) begin
                    lnk_nxt.cnt = 3'h0;
                    lnk_nxt.phase = sfm_pkg::PH_ADDR;
                    case (rxByte)
                        `SFM_OP_READ: lnk_nxt.txLanes = sfm_pkg::LN_ONE;
                        `SFM_OP_WRITE: lnk_nxt.isWrite = 1'b1;
                        `SFM_OP_DUAL_READ: lnk_nxt.txLanes = sfm_pkg::LN_TWO;
                        `SFM_OP_QUAD_READ: begin
                            lnk_nxt.txLanes = sfm_pkg::LN_FOUR;
                            lnk_nxt.quad = 1'b1;
                        end
                        `SFM_OP_QUAD_IO_READ: begin
                            lnk_nxt.rxLanes = sfm_pkg::LN_FOUR;
                            lnk_nxt.txLanes = sfm_pkg::LN_FOUR;
                            lnk_nxt.quad = 1'b1;
                        end
                        `SFM_OP_WRSR: lnk_nxt.phase = sfm_pkg::PH_STAT;
                        `SFM_OP_RDSR: begin
                            lnk_nxt.phase = sfm_pkg::PH_RDATA;
                            lnk_nxt.srcStatus = 1'b1;
                        end
                        default: lnk_nxt.phase = sfm_pkg::PH_IGNORE;
                    endcase
                end
            end
            sfm_pkg::PH_ADDR: begin
                lnk_nxt.shift = rxByte;
                lnk_nxt.cnt = lnk_r.cnt + 3'h1;
                if (byteDone) begin
                    lnk_nxt.cnt = 3'h0;
                    lnk_nxt.addr = {lnk_r.addr[15:0], rxByte};
                    lnk_nxt.addrBytes = lnk_r.addrBytes + 2'h1;
                    if (lnk_r.addrBytes == 2'(`SFM_ADDR_BYTES - 1)) begin
                        lnk_nxt.rxLanes = sfm_pkg::LN_ONE;
                        lnk_nxt.phase = lnk_r.isWrite ? sfm_pkg::PH_WDATA : sfm_pkg::PH_RDATA;
                    end
                end
            end
            sfm_pkg::PH_WDATA: begin
                lnk_nxt.shift = rxByte;
                lnk_nxt.cnt = lnk_r.cnt + 3'h1;
                if (byteDone) begin
                    // Each byte is handed over as soon as it completes
                    lnk_nxt.cnt = 3'h0;
                    keep_nxt.wrWord = {lnk_r.addr[`SFM_ADDR_USED-1:0], rxByte};
                    keep_nxt.wrTgl = !keep_r.wrTgl;
                    lnk_nxt.addr = lnk_r.addr + 24'h00_0001;
                end
            end
            sfm_pkg::PH_STAT: begin
                lnk_nxt.shift = rxByte;
                lnk_nxt.cnt = lnk_r.cnt + 3'h1;
                if (byteDone) begin
                    lnk_nxt.phase = sfm_pkg::PH_IGNORE;
                    if (laneIn[2] || !keep_r.statusReg[`SFM_SWD_BIT]) begin
                        keep_nxt.statusReg = rxByte;
                    end
                end
            end
            sfm_pkg::PH_RDATA: begin
                lnk_nxt.cnt = lnk_r.cnt + 3'h1;
                if (lnk_r.cnt == lastCnt(lnk_r.txLanes)) begin
                    lnk_nxt.cnt = 3'h0;
                    if (!lnk_r.srcStatus) begin
                        lnk_nxt.addr = lnk_r.addr + 24'h00_0001;
                    end
                end
            end
            default: lnk_nxt = lnk_r;
        endcase
    end

    // ----------------------------------------
    // Falling edge: lane drivers
    // ----------------------------------------
    assign txByte = lnk_r.srcStatus ? keep_r.statusReg : memRdData;

    always_comb begin
        drv_nxt = '0;
        txShift = txByte;
        if (lnk_r.phase == sfm_pkg::PH_RDATA) begin
            case (lnk_r.txLanes)
                sfm_pkg::LN_TWO: begin
                    txShift = txByte << {lnk_r.cnt[1:0], 1'b0};
                    drv_nxt.laneOut = {2'b00, txShift[7:6]};
                    drv_nxt.laneOe = 4'h3;
                end
                sfm_pkg::LN_FOUR: begin
                    txShift = txByte << {lnk_r.cnt[0], 2'b00};
                    drv_nxt.laneOut = txShift[7:4];
                    drv_nxt.laneOe = 4'hF;
                end
                default: begin
                    txShift = txByte << lnk_r.cnt;
                    drv_nxt.laneOut = {2'b00, txShift[7], 1'b0};
                    drv_nxt.laneOe = 4'h2;
                end
            endcase
        end
    end

    // Shift state sampled on the rising edge only
    always_ff @(posedge sck or posedge linkRst) begin
        if (linkRst) begin
            lnk_r <= '0;
        end else begin
            lnk_r <= lnk_nxt;
        end
    end

    // Status and handover word survive deselect
    always_ff @(posedge sck or posedge hwRst) begin
        if (hwRst) begin
            keep_r <= {`SFM_SR_RST, {($bits(sfm_pkg::sfm_wr_s) + 1){1'b0}}};
        end else begin
            keep_r <= keep_nxt;
        end
    end

    // Outputs launched on the falling edge, released at once on deselect
    always_ff @(negedge sck or posedge linkRst) begin
        if (linkRst) begin
            drv_r <= '0;
        end else begin
            drv_r <= drv_nxt;
        end
    end

    // ----------------------------------------
    // System clock side
    // ----------------------------------------
    assign push = (sys_r.tglStable != sys_r.tglSeen);

    always_comb begin
        sys_nxt = sys_r;
        sys_nxt.tglSync = {sys_r.tglSync[1:0], keep_r.wrTgl};
        sys_nxt.csSync = {sys_r.csSync[1:0], csN};
        // A change counts once the last two stages agree
        if (sys_r.tglSync[1] == sys_r.tglSync[2]) begin
            sys_nxt.tglStable = sys_r.tglSync[2];
        end
        if (sys_r.csSync[1] == sys_r.csSync[2]) begin
            sys_nxt.selected = !sys_r.csSync[2];
        end
        // Hold the event until the buffer takes it
        if (push && fifoReady) begin
            sys_nxt.tglSeen = sys_r.tglStable;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sys_r <= {{`SFM_SYNC_STAGES{1'b0}}, 2'b00, {`SFM_SYNC_STAGES{1'b1}}, 1'b0};
        end else begin
            sys_r <= sys_nxt;
        end
    end

    // Written bytes queue toward the array port
    sfm_fifo #(
        .WIDTH($bits(sfm_pkg::sfm_wr_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clock(clock),
        .srst(srst),
        .inValid(push),
        .inReady(fifoReady),
        .inData(keep_r.wrWord),
        .outValid(memWrValid),
        .outReady(memWrReady),
        .outData(fifoOut)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign laneOut = drv_r.laneOut;
    assign laneOe = drv_r.laneOe;
    assign memRdAddr = lnk_r.addr[`SFM_ADDR_USED-1:0];
    assign memWrAddr = fifoOut.addr;
    assign memWrData = fifoOut.data;
    assign hostSelected = sys_r.selected;
endmodule

`default_nettype wire

//--- sfm_spi_front_end_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfm_cfg.svh"

// ----------------------------------------
// Port checker
// ----------------------------------------
module sfm_spi_front_end_checker (
    input wire logic clock,
    input wire logic srst,
    input wire logic sck,
    input wire logic csN,
    input wire logic [3:0] laneIn,
    input wire logic [3:0] laneOut,
    input wire logic [3:0] laneOe,
    input wire logic memWrValid,
    input wire logic memWrReady,
    input wire logic [`SFM_ADDR_USED-1:0] memWrAddr,
    input wire logic [7:0] memWrData,
    input wire logic hostSelected
);
    logic [3:0] snapOut_r;

    // Output value seen at each sampling edge
    always_ff @(posedge sck) begin
        snapOut_r <= laneOut;
    end

    deselHiZ_a: assert property (@(posedge clock) disable iff (srst) csN |-> laneOe == 4'h0)
        else $error("lanes driven while deselected");
    oeLegal_a: assert property (@(posedge clock) disable iff (srst) laneOe inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("illegal lane enable set");
    rstHiZ_a: assert property (@(posedge clock) disable iff (srst) (!laneIn[3] && !laneOe[3]) |-> laneOe == 4'h0)
        else $error("lanes driven while reset pin low");
    holdHigh_a: assert property (@(negedge sck) disable iff (csN) laneOe != 4'h0 |-> laneOut == snapOut_r)
        else $error("output moved outside falling edge");
    oeHold_a: assert property (@(posedge clock) disable iff (csN || srst || !laneIn[3])
        laneOe != 4'h0 |=> laneOe == $past(laneOe))
        else $error("lane enables changed inside frame");
    selFall_a: assert property (@(posedge clock) disable iff (srst) $fell(csN) |-> ##[1:6] hostSelected)
        else $error("select not seen on system side");
    selRise_a: assert property (@(posedge clock) disable iff (srst) $rose(csN) |-> ##[1:6] !hostSelected)
        else $error("deselect not seen on system side");
    wrHold_a: assert property (@(posedge clock) disable iff (srst) (memWrValid && !memWrReady)
        |=> memWrValid && $stable(memWrAddr) && $stable(memWrData))
        else $error("write word dropped while stalled");
    rstClr_a: assert property (@(posedge clock) srst |=> !memWrValid && !hostSelected)
        else $error("system outputs active in reset");
endmodule

bind sfm_spi_front_end sfm_spi_front_end_checker u_chk (
    .clock(clock), .srst(srst), .sck(sck), .csN(csN), .laneIn(laneIn), .laneOut(laneOut),
    .laneOe(laneOe), .memWrValid(memWrValid), .memWrReady(memWrReady), .memWrAddr(memWrAddr),
    .memWrData(memWrData), .hostSelected(hostSelected)
);

`default_nettype wire

//--- sfm_spi_front_end_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfm_cfg.svh"

module sfm_spi_front_end_tb_top;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic memWrReady = 1'b0;
    logic sck;
    logic csN;
    logic [3:0] laneIn;
    logic [3:0] laneOut;
    logic [3:0] laneOe;
    logic [`SFM_ADDR_USED-1:0] memRdAddr;
    logic [7:0] memRdData;
    logic memWrValid;
    logic [`SFM_ADDR_USED-1:0] memWrAddr;
    logic [7:0] memWrData;
    logic hostSelected;
    logic [7:0] r0;
    int n_errors = 0;
    int checks = 0;

    // ----------------------------------------
    // Clock, array model and instances
    // ----------------------------------------
    always #20 clock = ~clock;

    function automatic logic [7:0] memf(input logic [18:0] a);
        return a[7:0] ^ {a[18:16], 5'h00} ^ 8'h5A;
    endfunction
    assign memRdData = memf(memRdAddr);

    sfm_spi_front_end DUT (
        .clock(clock), .srst(srst), .sck(sck), .csN(csN), .laneIn(laneIn), .laneOut(laneOut),
        .laneOe(laneOe), .memRdAddr(memRdAddr), .memRdData(memRdData), .memWrValid(memWrValid),
        .memWrReady(memWrReady), .memWrAddr(memWrAddr), .memWrData(memWrData), .hostSelected(hostSelected)
    );
    sfm_master master (.sck(sck), .csN(csN), .laneIn(laneIn), .laneOut(laneOut), .laneOe(laneOe));

    // ----------------------------------------
    // Checking and access tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic hdr(input logic [7:0] op, input logic [23:0] a, input int aw);
        master.start();
        master.xfer(op, 1, 1'b1, r0);
        for (int i = 2; i >= 0; i--) master.xfer(a[8 * i +: 8], aw, 1'b1, r0);
    endtask

    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int aw, input int dw, input logic [3:0] oe);
        hdr(op, a, aw);
        chk(hostSelected, 1'b1);
        for (int i = 0; i < 2; i++) begin
            master.xfer(8'h00, dw, 1'b0, r0);
            chk(r0, memf(a[18:0] + 19'(i)));
            chk(master.lastOe, oe);
        end
        master.stop();
        chk({laneOe, hostSelected}, 5'h00);
    endtask

    task automatic wrsr(input logic [7:0] v);
        master.start();
        master.xfer(`SFM_OP_WRSR, 1, 1'b1, r0);
        master.xfer(v, 1, 1'b1, r0);
        master.stop();
    endtask

    task automatic rdsr(input logic [7:0] e);
        master.start();
        master.xfer(`SFM_OP_RDSR, 1, 1'b1, r0);
        master.xfer(8'h00, 1, 1'b0, r0);
        chk(r0, e);
        master.stop();
    endtask

    task automatic wt();
        int k;
        k = 0;
        while (memWrValid !== 1'b1 && k < 50) begin
            @(negedge clock);
            k++;
        end
        if (memWrValid !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t write word timeout", $time);
            end_sim();
        end
    endtask

    // Run limit
    initial begin
        #1_000_000;
        n_errors++;
        $display("[ERR] %0t run timeout", $time);
        end_sim();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        #13;
        // Power-up: reset pin low plus a select pulse so link and status flops start known
        master.rstN = 1'b0;
        master.csN = 1'b0;
        #40 master.csN = 1'b1;
        #40 master.rstN = 1'b1;
        repeat (3) @(posedge clock);
        @(negedge clock) srst = 1'b0;
        chk({laneOe, memWrValid, hostSelected}, 6'h00);
        $display("test reset done");
        master.wpN = 1'b0;
        wrsr(8'h84);
        rdsr(8'h84);
        wrsr(8'h00);
        rdsr(8'h84);
        master.wpN = 1'b1;
        wrsr(8'h80);
        rdsr(8'h80);
        hdr(`SFM_OP_READ, 24'h00_0100, 1);
        master.xfer(8'h00, 1, 1'b0, r0);
        master.rstN = 1'b0;
        #10 chk(laneOe, 4'h0);
        #100 master.rstN = 1'b1;
        master.stop();
        rdsr(8'h00);
        $display("test status done");
        master.start();
        master.xfer(`SFM_OP_READ, 1, 1'b1, r0);
        master.xfer(8'h01, 1, 1'b1, r0);
        master.stop();
        chk(laneOe, 4'h0);
        rdsr(8'h00);
        master.start();
        master.xfer(8'h9F, 1, 1'b1, r0);
        master.xfer(8'h00, 1, 1'b0, r0);
        chk(master.lastOe, 4'h0);
        master.stop();
        $display("test abort done");
        rd(`SFM_OP_DUAL_READ, 24'h01_0F0F, 1, 2, 4'h3);
        rd(`SFM_OP_QUAD_READ, 24'h05_5AA5, 1, 4, 4'hF);
        rd(`SFM_OP_QUAD_IO_READ, 24'hFF_3C3C, 4, 4, 4'hF);
        rd(`SFM_OP_READ, 24'h07_FFFF, 1, 1, 4'h2);
        master.mode3 = 1'b1;
        rd(`SFM_OP_READ, 24'h02_1357, 1, 1, 4'h2);
        master.mode3 = 1'b0;
        $display("test reads done");
        hdr(`SFM_OP_WRITE, 24'hF7_FFF8, 1);
        for (int i = 0; i < 17; i++) master.xfer(8'(8'hC0 + i), 1, 1'b1, r0);
        master.stop();
        repeat (20) @(negedge clock);
        chk(memWrValid, 1'b1);
        for (int i = 0; i < 17; i++) begin
            wt();
            chk(memWrData, 8'(8'hC0 + i));
            chk(memWrAddr, 19'(19'h7_FFF8 + i));
            @(negedge clock) memWrReady = 1'b1;
            @(negedge clock) memWrReady = 1'b0;
        end
        repeat (20) @(negedge clock);
        chk(memWrValid, 1'b0);
        $display("test writes done");
        end_sim();
    end
endmodule

`default_nettype wire
